// [shared/osct_map.vh]
// register offsets, field positions, reset values and oscillator figures
`ifndef OSCT_MAP_VH
`define OSCT_MAP_VH

// register offsets
`define OSCT_ADDR_SAMPLE_CTRL 8'h4B
`define OSCT_ADDR_TIMING_TRIM 8'h4D

// sample clock control fields
`define OSCT_SC_TRIM_MSB 5
`define OSCT_SC_TRIM_LSB 0
`define OSCT_SC_POWER_BIT 7
`define OSCT_SC_RESET 16'h2612

// timing clock trim fields
`define OSCT_TC_TRIM_MSB 7
`define OSCT_TC_TRIM_LSB 0
`define OSCT_TC_RESET 16'h0098

// system clock rate
`define OSCT_CLK_HZ 125000000

// sample oscillator: centre at middle code, step per code
`define OSCT_SC_CEN_HZ 32000
`define OSCT_SC_MID_CODE 34
`define OSCT_SC_STEP_HZ 600

// timing oscillator: default at reset code, step per code
`define OSCT_TC_DEF_HZ 32000000
`define OSCT_TC_DEF_CODE 152
`define OSCT_TC_STEP_HZ 109000

`endif

// [hdl/osct_nco.v]
// phase-accumulator oscillator giving a clock level and a wrap tick
`timescale 1ns/100ps
`default_nettype none

module osct_nco #(
  parameter ACC_W = 32
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // control
  input wire i_en,
  input wire [ACC_W-1:0] i_inc,
  // outputs
  output reg o_clk_lvl,
  output reg o_tick
);

  reg [ACC_W-1:0] acc_reg;
  wire [ACC_W:0] sum_next;

  assign sum_next = {1'b0, acc_reg} + {1'b0, i_inc};

  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_reg <= {ACC_W{1'b0}};
      o_clk_lvl <= 1'b0;
      o_tick <= 1'b0;
    end else if (!i_en) begin
      // stopped: phase cleared, clock held low
      acc_reg <= {ACC_W{1'b0}};
      o_clk_lvl <= 1'b0;
      o_tick <= 1'b0;
    end else begin
      acc_reg <= sum_next[ACC_W-1:0];
      o_clk_lvl <= sum_next[ACC_W-1];
      o_tick <= sum_next[ACC_W];
    end
  end

endmodule // osct_nco

`default_nettype wire

// [hdl/osct_trim.v]
// trim registers and trimmed sample and timing oscillators
//
// What this block does
// - sample clock moves 0.6 kHz per step
// - larger sample code gives lower frequency
// - sample code zero max, 0x22 centre
// - timing clock moves 109 kHz per step
// - timing code rises with frequency, 0x98 default
// - sample trim sets the sample clock rate
// - sample clock runs only while power bit set
`timescale 1ns/100ps
`default_nettype none
`include "osct_map.vh"

module osct_trim #(
  parameter CLK_HZ = `OSCT_CLK_HZ,
  parameter ACC_W = 32
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // register port
  input wire [7:0] i_reg_addr,
  input wire [15:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [15:0] o_reg_rdata,
  output reg o_reg_rvalid,
  // sample oscillator
  output wire o_sample_clk,
  output wire o_sample_tick,
  // timing oscillator
  output wire o_timing_clk,
  output wire o_timing_tick
);

  localparam [63:0] SC_STEP_INC = (64'd`OSCT_SC_STEP_HZ << ACC_W) / CLK_HZ;
  localparam [63:0] SC_MAX_INC = ((64'd`OSCT_SC_CEN_HZ +
    64'd`OSCT_SC_MID_CODE * 64'd`OSCT_SC_STEP_HZ) << ACC_W) / CLK_HZ;
  localparam [63:0] TC_STEP_INC = (64'd`OSCT_TC_STEP_HZ << ACC_W) / CLK_HZ;
  localparam [63:0] TC_MIN_INC = ((64'd`OSCT_TC_DEF_HZ -
    64'd`OSCT_TC_DEF_CODE * 64'd`OSCT_TC_STEP_HZ) << ACC_W) / CLK_HZ;

  reg [15:0] sample_ctrl_reg;
  reg [15:0] timing_trim_reg;
  reg [ACC_W-1:0] sample_inc_reg;
  reg [ACC_W-1:0] timing_inc_reg;
  reg sample_run_reg;
  wire [5:0] sample_clock_trim;
  wire [7:0] timing_clock_trim;

  // linear step of a code onto a phase increment
  function [ACC_W-1:0] step_inc;
    input [63:0] base;
    input [63:0] step;
    input [7:0] code;
    input down;
    reg [63:0] prod;
    begin
      prod = step * {56'h0, code};
      if (down) begin
        step_inc = base[ACC_W-1:0] - prod[ACC_W-1:0];
      end else begin
        step_inc = base[ACC_W-1:0] + prod[ACC_W-1:0];
      end
    end
  endfunction

  assign sample_clock_trim = sample_ctrl_reg[`OSCT_SC_TRIM_MSB:`OSCT_SC_TRIM_LSB];
  assign timing_clock_trim = timing_trim_reg[`OSCT_TC_TRIM_MSB:`OSCT_TC_TRIM_LSB];

  // register writes; reserved bits stored as written
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_ctrl_reg <= `OSCT_SC_RESET;
      timing_trim_reg <= `OSCT_TC_RESET;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `OSCT_ADDR_SAMPLE_CTRL) begin
        sample_ctrl_reg <= i_reg_wdata;
      end
      if (i_reg_addr == `OSCT_ADDR_TIMING_TRIM) begin
        timing_trim_reg <= i_reg_wdata;
      end
    end
  end

  // register reads, unmapped reads zero
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_reg_rdata <= 16'h0000;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (!i_reg_rd) begin
        o_reg_rdata <= 16'h0000;
      end else if (i_reg_addr == `OSCT_ADDR_SAMPLE_CTRL) begin
        o_reg_rdata <= sample_ctrl_reg;
      end else if (i_reg_addr == `OSCT_ADDR_TIMING_TRIM) begin
        o_reg_rdata <= timing_trim_reg;
      end else begin
        o_reg_rdata <= 16'h0000;
      end
    end
  end

  // frequency words from trim codes
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sample_inc_reg <= {ACC_W{1'b0}};
      timing_inc_reg <= {ACC_W{1'b0}};
      sample_run_reg <= 1'b0;
    end else begin
      sample_inc_reg <= step_inc(SC_MAX_INC, SC_STEP_INC, {2'b00, sample_clock_trim}, 1'b1);
      timing_inc_reg <= step_inc(TC_MIN_INC, TC_STEP_INC, timing_clock_trim, 1'b0);
      sample_run_reg <= sample_ctrl_reg[`OSCT_SC_POWER_BIT];
    end
  end

  osct_nco #(
    .ACC_W(ACC_W)
  ) u_sample_nco (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_en(sample_run_reg),
    .i_inc(sample_inc_reg),
    .o_clk_lvl(o_sample_clk),
    .o_tick(o_sample_tick)
  );

  osct_nco #(
    .ACC_W(ACC_W)
  ) u_timing_nco (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_en(1'b1),
    .i_inc(timing_inc_reg),
    .o_clk_lvl(o_timing_clk),
    .o_tick(o_timing_tick)
  );

endmodule // osct_trim

`default_nettype wire

// [tb/osct_trim_props.sv]
// assertions on the trim block ports
`timescale 1ns/100ps
`default_nettype none
module osct_trim_props (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_reg_addr,
  input wire logic [15:0] i_reg_wdata,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  input wire logic o_sample_clk,
  input wire logic o_sample_tick,
  input wire logic o_timing_clk,
  input wire logic o_timing_tick
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire m = i_reg_addr == 8'h4B || i_reg_addr == 8'h4D;
  a_rd_answer: assert property (i_reg_rd |=> o_reg_rvalid) else $error("rvalid");
  a_rv_pulse: assert property (!i_reg_rd |=> !o_reg_rvalid) else $error("pulse");
  a_rdata_idle: assert property (!o_reg_rvalid |-> o_reg_rdata == 16'h0000) else $error("idle");
  a_unmapped_zero: assert property (i_reg_rd && !m |=> o_reg_rdata == 16'h0000) else $error("map");
  a_trim_keep: assert property (i_reg_wr && i_reg_addr == 8'h4D ##1 i_reg_rd && !i_reg_wr
    && i_reg_addr == 8'h4D |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("keep");
  a_sample_stop: assert property (i_reg_wr && i_reg_addr == 8'h4B && !i_reg_wdata[7] ##1
    !i_reg_wr |=> ##1 !o_sample_clk && !o_sample_tick) else $error("stop");
  a_sample_tick: assert property (o_sample_tick |=> !o_sample_tick [*8]) else $error("stk");
  a_timing_alive: assert property (o_timing_tick |-> ##[1:9] o_timing_tick) else $error("ttk");
endmodule // osct_trim_props
bind osct_trim osct_trim_props u_props (
  .i_clk(i_clk),
  .i_nrst(i_nrst),
  .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata),
  .i_reg_wr(i_reg_wr),
  .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata),
  .o_reg_rvalid(o_reg_rvalid),
  .o_sample_clk(o_sample_clk),
  .o_sample_tick(o_sample_tick),
  .o_timing_clk(o_timing_clk),
  .o_timing_tick(o_timing_tick)
);
`default_nettype wire

// [tb/osct_trim_tb.sv]
// self-checking bench for the trim block
`timescale 1ns/100ps
`default_nettype none
module osct_trim_tb;
  logic i_clk = 0, i_nrst = 0, i_reg_wr = 0, i_reg_rd = 0;
  logic [7:0] i_reg_addr = 0;
  logic [15:0] i_reg_wdata = 0;
  wire [15:0] o_reg_rdata;
  wire o_reg_rvalid, o_sample_clk, o_sample_tick, o_timing_clk, o_timing_tick;
  int n_errors = 0, n_checks = 0, s = 92070, mr[int];
  osct_trim u_dut (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata),
    .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd),
    .o_reg_rdata(o_reg_rdata),
    .o_reg_rvalid(o_reg_rvalid),
    .o_sample_clk(o_sample_clk),
    .o_sample_tick(o_sample_tick),
    .o_timing_clk(o_timing_clk),
    .o_timing_tick(o_timing_tick)
  );
  initial forever #4 i_clk = ~i_clk;
  function int rnd();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task chk(string n, logic [63:0] e, logic [63:0] v);
    n_checks++;
    if (v !== e) begin
      n_errors++;
      $display("wrong value %s exp %0h got %0h", n, e, v);
    end
  endtask
  task wr(logic [7:0] a, logic [15:0] d);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(posedge i_clk) #1 i_reg_wr = 0;
    if (a == 8'h4B || a == 8'h4D) mr[a] = d;
  endtask
  task rd(logic [7:0] a);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(posedge i_clk) #1 i_reg_rd = 0;
    chk("rvalid", 1, o_reg_rvalid);
    chk("rdata", mr.exists(a) ? mr[a] : 0, o_reg_rdata);
    // idle edge: strobe and data drop back to zero one cycle after the read
    @(posedge i_clk) #1;
    chk("rvalid idle", 0, o_reg_rvalid);
    chk("rdata idle", 0, o_reg_rdata);
  endtask
  // tick count over w cycles against the nco rate
  task automatic tk(bit p, int c, int w, bit on);
    logic [63:0] i = !on ? 0 : p ? (64'd52400 << 32) / 125000000 - c * ((64'd600 << 32) / 125000000)
      : (64'd15432000 << 32) / 125000000 + c * ((64'd109000 << 32) / 125000000);
    int n = 0;
    int r = 0;
    logic pl;
    if (p) wr(8'h4B, 16'h2600 | (on << 7) | c);
    else wr(8'h4D, c);
    repeat (3) @(posedge i_clk);
    #1 pl = p ? o_sample_clk : o_timing_clk;
    repeat (w) begin
      @(posedge i_clk) #1;
      n += p ? o_sample_tick : o_timing_tick;
      r += (p ? o_sample_clk : o_timing_clk) & !pl;
      pl = p ? o_sample_clk : o_timing_clk;
    end
    i = i * w >> 32;
    chk("ticks", i + (on && n == i + 1), n);
    chk("rises", i + (on && r == i + 1), r);
    if (!on) chk("stopped clk", 0, p ? o_sample_clk : o_timing_clk);
    rd(p ? 8'h4B : 8'h4D);
  endtask
  task summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #800000 n_errors++;
    summarize();
  end
  initial begin
    int sc[4] = '{0, 34, 63, 0};
    int tc[4] = '{0, 152, 255, 0};
    mr[8'h4B] = 16'h2612;
    mr[8'h4D] = 16'h0098;
    sc[3] = rnd() & 63;
    tc[3] = rnd() & 255;
    repeat (3) @(posedge i_clk);
    #1 i_nrst = 1;
    rd(8'h4B);
    rd(8'h4D);
    wr(8'h4C, 16'h1234);
    rd(8'h4C);
    wr(8'h4D, 16'h00FF);
    rd(8'h4D);
    for (int k = 0; k < 4; k++) tk(0, tc[k], 6000, 1);
    for (int k = 0; k < 4; k++) tk(1, sc[k], 12000, 1);
    tk(1, 34, 6000, 0);
    // mid-run reset brings both registers back to their defaults
    i_nrst = 0;
    repeat (3) @(posedge i_clk);
    #1 chk("reset outs", 4'h0, {o_reg_rvalid, o_timing_clk, o_timing_tick, o_sample_clk});
    i_nrst = 1;
    mr[8'h4B] = 16'h2612;
    mr[8'h4D] = 16'h0098;
    rd(8'h4B);
    rd(8'h4D);
    summarize();
  end
endmodule // osct_trim_tb
`default_nettype wire
